/* logic/dual_timer_timebase_watchdog.sv */
// two reload timers, a time base divider and a watchdog
// assumes an apb master on clk and mode info from the core
//
// Functional notes
// RL1: two 16-bit counters, byte preload registers
// RL2: enabled counter decrements once per tick
// RL3: interrupt on wrap from zero to ones
// RL4: reload from preload bytes on underflow
// RL5: underflow period is preload plus one
// RL6: timer a slow clock, fast if fast-only
// RL7: reset clears counter, first tick underflows
// RL8: firmware loads preload before enabling
// RL9: timer a mask bit 2, preload 3 and 4
// RL10: timer a runs while control bit 2 set
// RL11: timer b ticks at system clock over 1.5
// RL12: timer b mask bit 1, preload 5 and 6
// RL13: timer b runs while control bit 3 set
// RL14: time base divides slow clock by select
// RL15: time base enable bit 4, select write-only
// RL16: watchdog exists only with build option
// RL17: watchdog resets after 32768 timer a ticks
// RL18: clear instruction restarts watchdog count
// RL19: firmware clears watchdog often enough
// RL20: watchdog runs except in sleep
// RL21: dual mode: timer a, time base on slow
// RL22: request only when its enable bit set
// RL23: time base disable holds divider at zero
//
// Implementation choice: the APB register port.
`include "dtw_params.svh"
`timescale 1ns/10ps
`default_nettype none
module dual_timer_timebase_watchdog #(
  parameter int unsigned SLOW_DIV = `CLK_HZ / `SLOW_CLK_HZ,  // cycles per slow tick
  parameter int unsigned FAST_DIV = `CLK_HZ / `FAST_CLK_HZ,  // cycles per fast tick
  parameter bit          WATCHDOG_BUILD_OPTION = 1'b1        // watchdog fitted
) (
  input  wire logic             clk,            // 200 MHz core clock
  input  wire logic             sys_rst,        // async reset, high
  input  wire logic             psel,           // apb select
  input  wire logic             penable,        // apb access phase
  input  wire logic             pwrite,         // apb direction
  input  wire logic [7:0]       paddr,          // apb byte address
  input  wire logic [31:0]      pwdata,         // apb write data
  output logic      [31:0]      prdata,         // apb read data
  output logic                  pready,         // apb ready
  output logic                  pslverr,        // apb error
  input  wire dtw_pkg::op_mode_e opMode,        // core operating mode
  input  wire logic             watchdogClear,  // clear instruction pulse
  output dtw_pkg::irq_s         irqReq,         // interrupt pulses
  output logic                  watchdogReset   // system reset pulse
);
  import dtw_pkg::*;

  // ====================================================
  // clock-rate dividers
  // one-cycle enables stand in for the slow and fast clocks
  logic [15:0] slowDiv_reg;  // slow clock phase
  logic [15:0] fastDiv_reg;  // fast clock phase
  logic        slowTick;     // one slow clock edge
  logic        fastTick;     // one fast clock edge

  // a tick is the last count of its divider, so the first slow
  // tick lands SLOW_DIV cycles after reset, not at once
  assign slowTick = (slowDiv_reg == 16'(SLOW_DIV - 1));
  assign fastTick = (fastDiv_reg == 16'(FAST_DIV - 1));

  // free-running slow divider
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slowDiv_reg <= `RST_COUNT;
    end else if (slowTick) begin
      slowDiv_reg <= `RST_COUNT;
    end else begin
      slowDiv_reg <= slowDiv_reg + 16'h0001;
    end
  end

  // free-running fast divider
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fastDiv_reg <= `RST_COUNT;
    end else if (fastTick) begin
      fastDiv_reg <= `RST_COUNT;
    end else begin
      fastDiv_reg <= fastDiv_reg + 16'h0001;
    end
  end

  // ====================================================
  // clock source selection per mode
  logic timerATick;  // timer a source edge
  logic sysTick;     // system clock edge
  logic slowRun;     // slow clock alive
  logic timerBTick;  // timer b source edge
  logic [1:0] phase_reg;  // divide by 1.5 phase

  // sleep stops every source, idle keeps only the slow one
  always_comb begin
    slowRun    = slowTick & (opMode != MODE_SLEEP);
    timerATick = slowRun;                            // see RL21
    sysTick    = 1'b0;
    unique case (opMode)
      MODE_FAST_ONLY: begin
        timerATick = fastTick;                       // see RL6
        sysTick    = fastTick;
      end
      MODE_DUAL: begin
        sysTick = fastTick;
      end
      MODE_SLOW_ONLY: begin
        sysTick = slowTick;
      end
      MODE_IDLE: begin
        sysTick = 1'b0;  // core clock halted
      end
      MODE_SLEEP: begin
        sysTick = 1'b0;
      end
      default: begin
        sysTick = 1'b0;  // illegal mode code, system clock held still
      end
    endcase
  end

  // phase 0 drops one system tick in three; any even run of
  // timer b ticks spans an exact multiple of three system ticks
  // two timer b ticks for every three system ticks
  assign timerBTick = sysTick & (phase_reg != 2'h0);  // see RL11

  // phase of the 1.5 divider
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg <= 2'h0;
    end else if (sysTick) begin
      phase_reg <= (phase_reg == `TB_PHASE_LAST) ? 2'h0 : phase_reg + 2'h1;
    end
  end

  // ====================================================
  // software-visible control registers
  logic [7:0] irqEnable_reg;  // interrupt enables
  logic [7:0] preALow_reg;    // timer a low byte
  logic [7:0] preAHigh_reg;   // timer a high byte
  logic [7:0] preBLow_reg;    // timer b low byte
  logic [7:0] preBHigh_reg;   // timer b high byte
  logic [7:0] opCtlOne_reg;   // run bits
  logic       tbEnable_reg;   // time base enable
  logic [3:0] tbSelect_reg;   // time base rate select
  logic [5:0] index;          // word index
  logic       hit;            // mapped address
  logic       wrStrobe;       // write takes effect

  assign index    = paddr[7:2];
  assign wrStrobe = psel & penable & pwrite & hit;

  // address decode, misaligned counts as unmapped
  always_comb begin
    hit = (paddr[1:0] == `ADDR_LANE);
    unique case (index)
      `IDX_IRQ_EN, `IDX_TA_LOW, `IDX_TA_HIGH,
      `IDX_TB_LOW, `IDX_TB_HIGH, `IDX_OPCTL_ONE,
      `IDX_OPCTL_TWO, `IDX_STATUS: begin
        hit = hit;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // register writes, low byte lane only
  // upper write lanes are dropped; every writable register is one byte
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqEnable_reg <= `RST_BYTE;  // see RL9
      preALow_reg   <= `RST_BYTE;
      preAHigh_reg  <= `RST_BYTE;
      preBLow_reg   <= `RST_BYTE;
      preBHigh_reg  <= `RST_BYTE;
      opCtlOne_reg  <= `RST_BYTE;  // see RL10
      tbEnable_reg  <= 1'b0;       // see RL15
      tbSelect_reg  <= 4'h0;
    end else if (wrStrobe) begin
      unique case (index)
        `IDX_IRQ_EN: begin
          irqEnable_reg <= pwdata[7:0];     // see RL12
        end
        `IDX_TA_LOW: begin
          preALow_reg <= pwdata[7:0];       // see RL1
        end
        `IDX_TA_HIGH: begin
          preAHigh_reg <= pwdata[7:0];
        end
        `IDX_TB_LOW: begin
          preBLow_reg <= pwdata[7:0];
        end
        `IDX_TB_HIGH: begin
          preBHigh_reg <= pwdata[7:0];
        end
        `IDX_OPCTL_ONE: begin
          opCtlOne_reg <= pwdata[7:0];      // see RL13
        end
        `IDX_OPCTL_TWO: begin
          tbEnable_reg <= pwdata[`BIT_TB_ENABLE];
          tbSelect_reg <= pwdata[`TB_SEL_MSB:0];
        end
        default: begin
          // status is read-only, writes dropped
        end
      endcase
    end
  end

  // ====================================================
  // reload down-counters
  logic [15:0] countA_reg;   // timer a count
  logic [15:0] countB_reg;   // timer b count
  logic        runA;         // timer a enabled
  logic        runB;         // timer b enabled
  logic        underA;       // timer a wraps now
  logic        underB;       // timer b wraps now

  // the run bit gates the tick, so a stopped timer keeps its
  // count and resumes from it when enabled again
  assign runA   = opCtlOne_reg[`BIT_TA_RUN];
  assign runB   = opCtlOne_reg[`BIT_TB_RUN];
  // a zero count after reset wraps on the first tick
  assign underA = runA & timerATick & (countA_reg == `RST_COUNT);  // see RL7
  assign underB = runB & timerBTick & (countB_reg == `RST_COUNT);  // see RL3

  // timer a: decrement, reload on wrap
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      countA_reg <= `RST_COUNT;                      // see RL7
    end else if (underA) begin
      countA_reg <= {preAHigh_reg, preALow_reg};     // see RL4
    end else if (runA & timerATick) begin
      countA_reg <= countA_reg - 16'h0001;           // see RL2
    end
  end

  // timer b: same structure on its own source
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      countB_reg <= `RST_COUNT;
    end else if (underB) begin
      countB_reg <= {preBHigh_reg, preBLow_reg};     // see RL5
    end else if (runB & timerBTick) begin
      countB_reg <= countB_reg - 16'h0001;           // see RL2
    end
  end

  // ====================================================
  // time base divider
  logic [15:0] tbDiv_reg;  // slow ticks in period
  logic [15:0] tbLast;     // last count of period
  logic        tbFire;     // period ends now

  // code 0 halves the slow clock, each step halves again
  assign tbLast = (16'h0002 << tbSelect_reg) - 16'h0001;          // see RL14
  // greater-or-equal: lowering the select mid-period must not let
  // the divider run past its end and wrap the whole 16-bit range
  assign tbFire = tbEnable_reg & slowRun & (tbDiv_reg >= tbLast);

  // cleared while disabled so a restart gives a full period
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tbDiv_reg <= `RST_COUNT;
    end else if (!tbEnable_reg) begin
      tbDiv_reg <= `RST_COUNT;                       // see RL23
    end else if (tbFire) begin
      tbDiv_reg <= `RST_COUNT;
    end else if (slowRun) begin
      tbDiv_reg <= tbDiv_reg + 16'h0001;             // see RL15
    end
  end

  // ====================================================
  // interrupt requests, registered one-cycle pulses
  // no latching here: the core's own logic keeps pending state
  // the mask is sampled in the underflow cycle; the request one
  // cycle later follows the mask as it stood at the wrap
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqReq <= '0;
    end else begin
      irqReq.timerA   <= underA & irqEnable_reg[`BIT_TA_IRQ_EN];  // see RL22
      irqReq.timerB   <= underB & irqEnable_reg[`BIT_TB_IRQ_EN];  // see RL12
      irqReq.timeBase <= tbFire;
    end
  end

  // ====================================================
  // watchdog
  logic [14:0] wdtCount_reg;  // timer a source ticks
  logic        wdtTick;       // source alive, not sleeping

  // counts the timer a source, so sleep stops it
  // fifteen bits wrap after 32768 ticks, the overflow point;
  // in fast-only operation it fills far sooner than on slow
  assign wdtTick = timerATick;  // see RL20

  generate
    if (WATCHDOG_BUILD_OPTION) begin : g_wdt
      // clear beats a tick in the same cycle
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          wdtCount_reg  <= 15'h0000;
          watchdogReset <= 1'b0;
        end else begin
          watchdogReset <= 1'b0;
          if (watchdogClear) begin
            wdtCount_reg <= 15'h0000;                  // see RL18
          end else if (wdtTick) begin
            wdtCount_reg <= wdtCount_reg + 15'h0001;   // wraps to zero
            if (wdtCount_reg == `WDT_LAST) begin
              watchdogReset <= 1'b1;                   // see RL17
            end
          end
        end
      end
    end else begin : g_no_wdt
      // not fitted: never resets the system
      assign wdtCount_reg  = 15'h0000;                 // see RL16
      assign watchdogReset = 1'b0;
    end
  endgenerate

  // ====================================================
  // apb answer
  // zero wait states; data is captured in the setup cycle
  // writes land in the access cycle, so they need no capture;
  // a read shows the state as it stood in the setup cycle
  assign pready = 1'b1;

  // read data and error, registered at setup
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & !penable) begin
      pslverr <= !hit;
      prdata  <= 32'h0000_0000;
      if (!pwrite & hit) begin
        unique case (index)
          `IDX_IRQ_EN: begin
            prdata[`BIT_TA_IRQ_EN] <= irqEnable_reg[`BIT_TA_IRQ_EN];
            prdata[`BIT_TB_IRQ_EN] <= irqEnable_reg[`BIT_TB_IRQ_EN];
          end
          `IDX_OPCTL_ONE: begin
            prdata[`BIT_TA_RUN] <= runA;
            prdata[`BIT_TB_RUN] <= runB;
          end
          `IDX_OPCTL_TWO: begin
            // select bits are write-only and read zero
            prdata[`BIT_TB_ENABLE] <= tbEnable_reg;
          end
          `IDX_STATUS: begin
            prdata <= {countB_reg, countA_reg};
          end
          default: begin
            // preload bytes are write-only
          end
        endcase
      end
    end
  end

  // unused upper data bits of writes and the watchdog count
  // folded into one bit so no input is left dangling
  logic unusedBits;  // sink for ignored lanes
  assign unusedBits = ^{pwdata[31:8], wdtCount_reg};

endmodule : dual_timer_timebase_watchdog
`default_nettype wire

/* logic/dtw_params.svh */
// constants for the dual timer / time base / watchdog block
// assumes a 200 MHz core clock and a register index per word
`ifndef DTW_PARAMS_SVH
`define DTW_PARAMS_SVH
// ====================================================
// clock rates
`define CLK_HZ        200000000
`define SLOW_CLK_HZ   32768
`define FAST_CLK_HZ   8000000
// ====================================================
// register indexes, byte address is four times these
`define IDX_IRQ_EN    6'h02
`define IDX_TA_LOW    6'h03
`define IDX_TA_HIGH   6'h04
`define IDX_TB_LOW    6'h05
`define IDX_TB_HIGH   6'h06
`define IDX_OPCTL_ONE 6'h09
`define IDX_OPCTL_TWO 6'h0a
`define IDX_STATUS    6'h0b
// ====================================================
// field positions
`define BIT_TA_IRQ_EN 2
`define BIT_TB_IRQ_EN 1
`define BIT_TA_RUN    2
`define BIT_TB_RUN    3
`define BIT_TB_ENABLE 4
`define TB_SEL_MSB    3
// ====================================================
// reset values and counts
`define RST_BYTE      8'h00
`define RST_COUNT     16'h0000
`define COUNT_ONES    16'hffff
`define WDT_LAST      15'h7fff
`define TB_PHASE_LAST 2'h2
`define ADDR_LANE     2'h0
`endif

/* logic/dtw_pkg.sv */
// types shared by the timer block and its bench
// assumes the params header is compiled alongside
package dtw_pkg;
  // ====================================================
  // operating mode of the core, one-hot
  typedef enum logic [4:0] {
    MODE_FAST_ONLY = 5'b00001,  // fast clock only
    MODE_DUAL      = 5'b00010,  // fast core, timer a and time base slow
    MODE_SLOW_ONLY = 5'b00100,  // slow clock only
    MODE_IDLE      = 5'b01000,  // core halted, slow runs
    MODE_SLEEP     = 5'b10000   // all clocks halted
  } op_mode_e;
  // ====================================================
  // interrupt requests toward the core
  typedef struct packed {
    logic timeBase;  // time base period
    logic timerB;    // timer b underflow
    logic timerA;    // timer a underflow
  } irq_s;
endpackage : dtw_pkg

/* verification/dtw_checker_asserts.sv */
// checker for the timer block ports
// assumes the params header and dtw_pkg come first
`include "dtw_params.svh"
`timescale 1ns/10ps
`default_nettype none
module dtw_checker #(
  parameter bit WATCHDOG_BUILD_OPTION = 1'b1  // watchdog fitted
) (
  input wire logic              clk,           // core clock
  input wire logic              sys_rst,       // async reset
  input wire logic              psel,          // apb select
  input wire logic              penable,       // apb access
  input wire logic              pwrite,        // apb direction
  input wire logic [7:0]        paddr,         // apb address
  input wire logic [31:0]       pwdata,        // write data
  input wire logic [31:0]       prdata,        // read data
  input wire logic              pready,        // apb ready
  input wire logic              pslverr,       // apb error
  input wire dtw_pkg::op_mode_e opMode,        // core mode
  input wire logic              watchdogClear, // clear pulse
  input wire dtw_pkg::irq_s     irqReq,        // irq pulses
  input wire logic              watchdogReset  // reset pulse
);
  import dtw_pkg::*;
  // ====================================================
  // shadows of the gating bits, kept from bus writes
  logic [7:0] irqEn_reg;                                  // irq enable copy
  logic       tbOn_reg;                                   // time base enable copy
  wire        wrDone = psel && penable && pwrite && pready;  // write lands
  // masks may change around a pulse, so one cycle of slack below
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqEn_reg <= 8'h00;
      tbOn_reg  <= 1'b0;
    end else if (wrDone && paddr == {`IDX_IRQ_EN, 2'h0}) begin
      irqEn_reg <= pwdata[7:0];
    end else if (wrDone && paddr == {`IDX_OPCTL_TWO, 2'h0}) begin
      tbOn_reg <= pwdata[`BIT_TB_ENABLE];
    end
  end
  // cycles since the last clear, saturating; no reset may come
  // sooner than 32768 of them, whatever the divider ratio
  logic [16:0] sinceClr_reg;  // cycles since clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sinceClr_reg <= 17'h00000;
    end else if (watchdogClear) begin
      sinceClr_reg <= 17'h00000;
    end else if (!sinceClr_reg[16]) begin
      sinceClr_reg <= sinceClr_reg + 17'h00001;
    end
  end
  // ====================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_mask_timer_a: assert property (irqReq.timerA |-> irqEn_reg[2] || $past(irqEn_reg[2]))
    else $error("timer a request while masked");
  chk_mask_timer_b: assert property (irqReq.timerB |-> irqEn_reg[1] || $past(irqEn_reg[1]))
    else $error("timer b request while masked");
  chk_tbase_gate: assert property (irqReq.timeBase |-> tbOn_reg || $past(tbOn_reg))
    else $error("time base pulse while disabled");
  chk_irq_pulse: assert property (irqReq.timerA |=> !irqReq.timerA)
    else $error("timer a request longer than a cycle");
  chk_sleep_quiet: assert property ((opMode == MODE_SLEEP) [*3] |->
    !irqReq.timerA && !irqReq.timeBase && !watchdogReset)
    else $error("activity while asleep");
  chk_halt_timer_b: assert property ((opMode == MODE_IDLE || opMode == MODE_SLEEP) [*3] |-> !irqReq.timerB)
    else $error("timer b counted without system clock");
  chk_wdt_fitted: assert property (watchdogReset |->
    WATCHDOG_BUILD_OPTION && sinceClr_reg >= 17'h08000)
    else $error("watchdog reset without the option or too early");
  chk_clear_wins: assert property (watchdogClear |=> !watchdogReset)
    else $error("watchdog reset right after a clear");
  chk_wdt_pulse: assert property (watchdogReset |=> !watchdogReset)
    else $error("watchdog reset longer than a cycle");
  chk_err_addr: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  chk_ok_mapped: assert property (psel && !penable && paddr == {`IDX_IRQ_EN, 2'h0} |=> !pslverr)
    else $error("mapped access refused");
  chk_err_data: assert property (psel && penable && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
endmodule : dtw_checker
bind dual_timer_timebase_watchdog dtw_checker #(
  .WATCHDOG_BUILD_OPTION(WATCHDOG_BUILD_OPTION)
) dtw_checker_i (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .opMode, .watchdogClear, .irqReq, .watchdogReset);
`default_nettype wire

/* verification/core_bus_model.sv */
// model of the core: apb master and watchdog clearing
// assumes one clock shared with the timer block
`timescale 1ns/10ps
`default_nettype none
module core_bus_model (
  input  wire logic        clk,           // core clock
  input  wire logic        keepAlive,     // firmware still healthy
  input  wire logic [31:0] prdata,        // read data
  input  wire logic        pready,        // apb ready
  input  wire logic        pslverr,       // apb error
  output logic             psel,          // apb select
  output logic             penable,       // apb access
  output logic             pwrite,        // apb direction
  output logic [7:0]       paddr,         // apb address
  output logic [31:0]      pwdata,        // write data
  output logic             watchdogClear  // clear instruction
);
  int stuck = 0;  // transfers that never saw ready
  int since = 0;  // cycles since last clear slot, wraps at 500
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    watchdogClear = 1'b0;
  end
  // ====================================================
  // clear every 500 cycles, far inside the overflow count
  always @(posedge clk) begin
    since <= (since == 499) ? 0 : since + 1;
    watchdogClear <= keepAlive && since == 0;
  end
  // ====================================================
  // one apb transfer; request held until ready is sampled or 16 access cycles pass
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!pready && n < 16);
    if (!pready) stuck++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;  // stale data must not look valid
  endtask : xfer
endmodule : core_bus_model
`default_nettype wire

/* verification/dual_timer_timebase_watchdog_tb.sv */
// testbench for the timer block
// assumes package, params header and checker compiled first
`include "dtw_params.svh"
`timescale 1ns/10ps
`default_nettype none
module dual_timer_timebase_watchdog_tb;
  import dtw_pkg::*;
  localparam int SD = 4;     // short slow divider
  localparam int FD = 2;     // short fast divider
  localparam int LIM = 2000; // bound on each period wait
  localparam logic [7:0] A_IE = {`IDX_IRQ_EN, 2'h0};
  localparam logic [7:0] A_TAL = {`IDX_TA_LOW, 2'h0};
  localparam logic [7:0] A_TAH = {`IDX_TA_HIGH, 2'h0};
  localparam logic [7:0] A_TBL = {`IDX_TB_LOW, 2'h0};
  localparam logic [7:0] A_TBH = {`IDX_TB_HIGH, 2'h0};
  localparam logic [7:0] A_OP1 = {`IDX_OPCTL_ONE, 2'h0};
  localparam logic [7:0] A_OP2 = {`IDX_OPCTL_TWO, 2'h0};
  logic        clk = 1'b0;  // core clock
  logic        sysRst;      // reset to the block
  logic        keepAlive;   // core keeps clearing
  logic        psel, penable, pwrite, pready, pslverr, wdClr, wdRst;
  logic [7:0]  paddr;       // apb address
  logic [31:0] pwdata, prdata;
  op_mode_e    opMode;      // core mode
  irq_s        irqReq;      // requests
  int failures = 0, check_count = 0, wdHits = 0, seed = 55722, nA, nB, n;
  int expQ[$];              // expected gaps from the model
  always #2.5 clk = ~clk;
  dual_timer_timebase_watchdog #(.SLOW_DIV(SD), .FAST_DIV(FD), .WATCHDOG_BUILD_OPTION(1'b1))
    dual_timer_timebase_watchdog_i (.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .opMode(opMode), .watchdogClear(wdClr), .irqReq(irqReq), .watchdogReset(wdRst));
  core_bus_model core_i (.clk(clk), .keepAlive(keepAlive), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .watchdogClear(wdClr));
  // ====================================================
  // helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    core_i.xfer(1'b1, a, d, r, e);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] r;
    logic e;
    core_i.xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, expErr});
  endtask : rd
  // cycles until the next pulse on request b, capped at lim
  task nextPulse(input int b, input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (irqReq[b] !== 1'b1 && c < lim);
  endtask : nextPulse
  task per(input int b, input int e);
    int g;
    expQ.push_back(e);
    nextPulse(b, LIM, g);
    nextPulse(b, LIM, g);
    chk(g, expQ.pop_front());
  endtask : per
  task quiet(input int b, input int c);
    int g;
    repeat (2) @(posedge clk);
    nextPulse(b, c, g);
    chk({31'h0, irqReq[b]}, 32'h0);
  endtask : quiet
  task wrap_up();
    failures += core_i.stuck;
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // no reset while the core keeps clearing
  always @(posedge clk) if (keepAlive && !sysRst && wdRst === 1'b1) wdHits++;
  initial begin
    #(5 * 95000);
    failures++;
    wrap_up();
  end
  // ====================================================
  // main sequence
  initial begin
    sysRst = 1'b1;
    opMode = MODE_DUAL;
    keepAlive = 1'b1;
    repeat (12) @(posedge clk);
    sysRst <= 1'b0;
    rd(A_IE, 32'h0, 1'b0);
    rd(A_OP1, 32'h0, 1'b0);
    rd(A_OP2, 32'h0, 1'b0);
    rd(8'h3c, 32'h0, 1'b1);
    rd(8'h09, 32'h0, 1'b1);
    rd({`IDX_STATUS, 2'h0}, 32'h0, 1'b0);
    nA = $random(seed) & 7;
    wr(A_TAL, nA);
    wr(A_TAH, 32'h0);
    rd(A_TAL, 32'h0, 1'b0);
    wr(A_IE, 32'h06);
    rd(A_IE, 32'h06, 1'b0);
    wr(A_OP1, 32'h04);
    nextPulse(0, SD + 3, n);
    chk({31'h0, irqReq.timerA}, 32'h1);
    per(0, (nA + 1) * SD);
    wr(A_IE, 32'h02);
    quiet(0, 3 * (nA + 1) * SD + 8);
    wr(A_IE, 32'h06);
    @(posedge clk) opMode <= MODE_FAST_ONLY;
    per(0, (nA + 1) * FD);
    nB = 2 * ($random(seed) & 3) + 1;
    wr(A_TBL, nB);
    wr(A_TBH, 32'h0);
    wr(A_OP1, 32'h08);
    quiet(0, 40);
    per(1, (nB + 1) / 2 * 3 * FD);
    @(posedge clk) opMode <= MODE_SLOW_ONLY;
    per(1, (nB + 1) / 2 * 3 * SD);
    wr(A_OP1, 32'h04);
    quiet(1, 3 * (nB + 1) * SD);
    @(posedge clk) opMode <= MODE_DUAL;
    for (int s = 0; s < 4; s++) begin
      wr(A_OP2, 32'h10 | s);
      per(2, (2 << s) * SD);
    end
    rd(A_OP2, 32'h10, 1'b0);
    wr(A_OP2, 32'h00);
    quiet(2, 40);
    wr(A_OP2, 32'h13);
    nextPulse(2, LIM, n);
    chk({31'h0, n >= 15 * SD && n <= 16 * SD + 2}, 32'h1);
    wr(A_OP1, 32'h0c);
    @(posedge clk) opMode <= MODE_IDLE;
    quiet(1, 40);
    @(posedge clk) opMode <= MODE_SLEEP;
    quiet(0, 40);
    @(posedge clk) opMode <= MODE_FAST_ONLY;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wdClr !== 1'b1 && n < 600);
    chk({31'h0, n < 600}, 32'h1);
    keepAlive <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (wdRst !== 1'b1 && n < 70000);
    chk({31'h0, n >= 65534 && n <= 65538}, 32'h1);
    chk(wdHits, 32'h0);
    wrap_up();
  end
endmodule : dual_timer_timebase_watchdog_tb
`default_nettype wire
